/* shared/i2c_recov_pkg.sv */
// constants, layouts and state type for the recovering serial wiper slave
package i2c_recov_pkg;
   // bus addressing
   localparam int ADDR_W = 7;
   localparam logic [6:0] GC_ADDR = 7'h00;   // broadcast address
   localparam logic [6:0] DEV_ADDR = 7'h2E;  // own address, value arbitrary
   // command byte layout: [7:4] location, [3:2] operation, [0] data bit 8
   localparam int CMD_MEM_HI = 7;
   localparam int CMD_MEM_LO = 4;
   localparam int CMD_OP_HI = 3;
   localparam int CMD_OP_LO = 2;
   localparam int CMD_D8 = 0;
   localparam logic [3:0] MEM_VOL = 4'h0;    // volatile wiper
   localparam logic [3:0] MEM_NV = 4'h2;     // nonvolatile wiper
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_INC = 2'h1;
   localparam logic [1:0] OP_DEC = 2'h2;
   // wiper range and reset
   localparam int WIPER_W = 9;
   localparam logic [8:0] WIPER_MAX = 9'h100;
   localparam logic [8:0] WIPER_MIN = 9'h000;
   localparam logic [8:0] WIPER_RST = 9'h080;
   localparam logic [8:0] WIPER_STEP = 9'h001;
   // bit and byte counting
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_STEP = 4'h1;
   localparam logic [3:0] BIT_LAST = 4'h8;   // byte complete, ack slot next
   localparam logic [3:0] TX_LAST = 4'h7;    // last transmitted bit index
   localparam logic [1:0] IDX_ADDR = 2'h0;
   localparam logic [1:0] IDX_CMD = 2'h1;
   localparam logic [1:0] IDX_DATA = 2'h2;
   // serial interface states
   typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} slave_state_e;
endpackage

/* rtl/bus_sync.sv */
// pin synchroniser and bus event detector for clock and data lines
module bus_sync
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output logic scl_rise_o,
   output logic scl_fall_o,
   output logic start_o,
   output logic stop_o
);
   import i2c_recov_pkg::*;

   logic [2:0] scl_pipe; // meta, stable, delayed
   logic [2:0] sda_pipe; // meta, stable, delayed
   logic [2:0] next_scl_pipe;
   logic [2:0] next_sda_pipe;

   // shift both pins in; stage 0 is read only by stage 1
   always_comb
   begin
      next_scl_pipe = {scl_pipe[1:0], scl_i};
      next_sda_pipe = {sda_pipe[1:0], sda_i};
   end

   // register the pipes, lines idle high
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scl_pipe <= 3'h7;
         sda_pipe <= 3'h7;
      end
      else
      begin
         scl_pipe <= next_scl_pipe;
         sda_pipe <= next_sda_pipe;
      end
   end

   // stable levels and edges, from stages 1 and 2 only
   assign scl_o = scl_pipe[1];
   assign sda_o = sda_pipe[1];
   assign scl_rise_o = scl_pipe[1] && !scl_pipe[2];
   assign scl_fall_o = !scl_pipe[1] && scl_pipe[2];
   // data falls while clock stays high
   assign start_o = scl_pipe[1] && scl_pipe[2] && sda_pipe[2] && !sda_pipe[1];
   // data rises while clock stays high
   assign stop_o = scl_pipe[1] && scl_pipe[2] && !sda_pipe[2] && sda_pipe[1];
endmodule

/* rtl/wiper_slave.sv */
// serial wiper slave with bus recovery and broadcast update
// Summary of operation
// - start while receiving restarts the interface
// - slave driving data low cannot see start
// - master nack after sent byte resets interface
// - stop after complete command commits nonvolatile write
// - stop ends sequence; idle until next start
// - broadcast address accepts increment, decrement, write
// - recovery leaves wiper and stored values alone
// - nonvolatile write only after full command, stop
module wiper_slave
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [i2c_recov_pkg::WIPER_W-1:0] wiper_o,
   output logic nv_write_o,
   output logic [i2c_recov_pkg::WIPER_W-1:0] nv_data_o
);
   import i2c_recov_pkg::*;

   logic sda; // synchronised data line
   logic scl_rise, scl_fall; // synchronised clock edges
   logic start, stop; // bus start and stop conditions

   slave_state_e state, next_state;
   logic [3:0] cnt, next_cnt;             // bit counter
   logic [7:0] shift, next_shift;         // byte shifter
   logic [1:0] byte_idx, next_idx;        // address, command or data byte
   logic rd, next_rd;                     // read transfer
   logic [3:0] mem, next_mem;             // addressed location
   logic [1:0] op, next_op;               // operation of command
   logic d8, next_d8;                     // data bit 8 from command
   logic [8:0] wiper, next_wiper;         // volatile wiper
   logic nv_pend, next_nv_pend;           // complete nonvolatile write waiting
   logic [8:0] nv_data, next_nv_data;     // stored copy, changes only on commit
   logic [8:0] nv_hold, next_nv_hold;     // complete write value waiting for stop
   logic nv_go, next_nv_go;               // one-cycle commit pulse
   logic drive, next_drive;               // pull data line low
   logic cmd_ok;                          // command byte decodes
   logic [8:0] wr_val;                    // assembled write value

   bus_sync u_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_o(),
      .sda_o(sda),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall),
      .start_o(start),
      .stop_o(stop)
   );

   // command legal: known location, no stepping of stored copy
   assign cmd_ok = (shift[CMD_MEM_HI:CMD_MEM_LO] == MEM_VOL
                    && shift[CMD_OP_HI:CMD_OP_LO] != 2'h3)
                   || (shift[CMD_MEM_HI:CMD_MEM_LO] == MEM_NV
                    && shift[CMD_OP_HI:CMD_OP_LO] == OP_WRITE);
   // data value clipped to full scale
   assign wr_val = ({d8, shift} > WIPER_MAX) ? WIPER_MAX : {d8, shift};

   // interface sequencing
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_shift = shift;
      next_idx = byte_idx;
      next_rd = rd;
      next_mem = mem;
      next_op = op;
      next_d8 = d8;
      next_wiper = wiper;
      next_nv_pend = nv_pend;
      next_nv_data = nv_data;
      next_nv_hold = nv_hold;
      next_nv_go = 1'b0;
      next_drive = drive;
      if (stop)
      begin
         // stop ends activity, idle until next start
         next_state = S_IDLE;
         next_drive = 1'b0;
         // commit only a fully received command
         next_nv_go = nv_pend;
         next_nv_data = nv_pend ? nv_hold : nv_data;
         next_nv_pend = 1'b0;
      end
      else if (start)
      begin
         // restart: drop partial bytes, keep wiper values
         next_state = S_RX;
         next_cnt = CNT_ZERO;
         next_idx = IDX_ADDR;
         next_shift = 8'h00;
         next_nv_pend = 1'b0;
         next_drive = 1'b0;
      end
      else
      begin
         case (state)
            S_IDLE: next_drive = 1'b0; // bus activity ignored
            S_RX:
            begin
               if (scl_rise && cnt != BIT_LAST)
               begin
                  // sample one bit
                  next_shift = {shift[6:0], sda};
                  next_cnt = 4'(cnt + CNT_STEP);
               end
               else if (scl_fall && cnt == BIT_LAST)
               begin
                  // decide acknowledge for the byte
                  if (byte_idx == IDX_ADDR)
                  begin
                     if (shift[7:1] == DEV_ADDR
                         || (shift[7:1] == GC_ADDR && !shift[0]))
                     begin
                        next_rd = shift[0];
                        next_state = S_RX_ACK;
                        next_drive = 1'b1;
                     end
                     else
                        next_state = S_IDLE;
                  end
                  else if (byte_idx == IDX_CMD)
                  begin
                     if (cmd_ok)
                     begin
                        next_mem = shift[CMD_MEM_HI:CMD_MEM_LO];
                        next_op = shift[CMD_OP_HI:CMD_OP_LO];
                        next_d8 = shift[CMD_D8];
                        next_state = S_RX_ACK;
                        next_drive = 1'b1;
                     end
                     else
                        next_state = S_IDLE;
                  end
                  else
                  begin
                     // data byte always taken
                     next_state = S_RX_ACK;
                     next_drive = 1'b1;
                  end
               end
            end
            S_RX_ACK:
            begin
               // hold data low through the ack clock; no start visible
               if (scl_fall)
               begin
                  next_drive = 1'b0;
                  next_cnt = CNT_ZERO;
                  next_state = S_RX;
                  next_idx = IDX_CMD;
                  if (byte_idx == IDX_ADDR && rd)
                  begin
                     // first bit of read byte goes out now
                     next_state = S_TX;
                     next_shift = (mem == MEM_NV) ? nv_data[7:0] : wiper[7:0];
                     next_drive = (mem == MEM_NV) ? !nv_data[7] : !wiper[7];
                  end
                  else if (byte_idx == IDX_CMD && op == OP_WRITE)
                     next_idx = IDX_DATA;
                  else if (byte_idx == IDX_CMD)
                  begin
                     // step saturates at both ends
                     if (op == OP_INC && wiper < WIPER_MAX)
                        next_wiper = wiper + WIPER_STEP;
                     else if (op == OP_DEC && wiper > WIPER_MIN)
                        next_wiper = wiper - WIPER_STEP;
                  end
                  else if (byte_idx == IDX_DATA && mem == MEM_VOL)
                     next_wiper = wr_val;
                  else if (byte_idx == IDX_DATA)
                  begin
                     // value parked until stop; stored copy stays as read back
                     next_nv_pend = 1'b1;
                     next_nv_hold = wr_val;
                  end
               end
            end
            S_TX:
            begin
               if (scl_fall && cnt == TX_LAST)
               begin
                  // release for master ack
                  next_drive = 1'b0;
                  next_cnt = CNT_ZERO;
                  next_state = S_TX_ACK;
               end
               else if (scl_fall)
               begin
                  next_shift = {shift[6:0], 1'b0};
                  next_drive = !shift[6];
                  next_cnt = 4'(cnt + CNT_STEP);
               end
            end
            S_TX_ACK:
            begin
               if (scl_rise && sda)
                  next_state = S_IDLE; // master nack resets
               else if (scl_rise)
                  next_cnt = BIT_LAST;
               else if (scl_fall && cnt == BIT_LAST)
               begin
                  // acked: send next byte
                  next_state = S_TX;
                  next_cnt = CNT_ZERO;
                  next_shift = (mem == MEM_NV) ? nv_data[7:0] : wiper[7:0];
                  next_drive = (mem == MEM_NV) ? !nv_data[7] : !wiper[7];
               end
            end
            default: next_state = S_IDLE;
         endcase
      end
   end

   // register the interface state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= S_IDLE;
         cnt <= CNT_ZERO;
         shift <= 8'h00;
         byte_idx <= IDX_ADDR;
         rd <= 1'b0;
         mem <= MEM_VOL;
         op <= OP_WRITE;
         d8 <= 1'b0;
         wiper <= WIPER_RST;
         nv_pend <= 1'b0;
         nv_data <= WIPER_RST;
         nv_hold <= WIPER_RST;
         nv_go <= 1'b0;
         drive <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         shift <= next_shift;
         byte_idx <= next_idx;
         rd <= next_rd;
         mem <= next_mem;
         op <= next_op;
         d8 <= next_d8;
         wiper <= next_wiper;
         nv_pend <= next_nv_pend;
         nv_data <= next_nv_data;
         nv_hold <= next_nv_hold;
         nv_go <= next_nv_go;
         drive <= next_drive;
      end
   end

   // outputs; data line only ever pulled low
   assign sda_o = 1'b0;
   assign sda_oe_o = drive;
   assign wiper_o = wiper;
   assign nv_write_o = nv_go;
   assign nv_data_o = nv_data;

   chk_start_restart: assert property (@(posedge clk_i) disable iff (rst_i)
      start && !stop |=> state == S_RX && cnt == CNT_ZERO && byte_idx == IDX_ADDR)
      else $error("start did not restart reception");
   chk_drive_phase: assert property (@(posedge clk_i) disable iff (rst_i)
      sda_oe_o |-> state == S_RX_ACK || state == S_TX)
      else $error("data driven outside ack or transmit");
   chk_nack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_TX_ACK && scl_rise && sda && !start && !stop |=> state == S_IDLE)
      else $error("nack did not reset interface");
   chk_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_IDLE && !start |=> state == S_IDLE && !sda_oe_o)
      else $error("idle left without start");
   chk_nv_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      nv_write_o |-> $past(stop) && $past(nv_pend) ##1 !nv_write_o)
      else $error("nonvolatile write without stop");
   chk_start_cancel: assert property (@(posedge clk_i) disable iff (rst_i)
      start && !stop ##1 (!stop)[*2] |-> !nv_write_o && !nv_pend)
      else $error("pending write survived restart");
   chk_wiper_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      start || stop |=> wiper == $past(wiper) && (nv_data == $past(nv_data) || nv_write_o))
      else $error("recovery changed wiper");
   chk_gc_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_RX && scl_fall && cnt == BIT_LAST && byte_idx == IDX_ADDR
      && shift == 8'h00 && !start && !stop |=> state == S_RX_ACK && sda_oe_o)
      else $error("broadcast address not acknowledged");
endmodule

/* verif/i2c_master_model.sv */
// bus master model: drives the clock pin and pulls the data wire low
module i2c_master_model
(
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus: clock high, data released to the pull-up
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   // wait n falling edges of the system clock
   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // start: data falls while clock high; a slave holding data hides it
   task automatic start_c();
      w(1);
      sda_pull_o = 1'b0;
      w(4);
      scl_o = 1'b1;
      w(4);
      sda_pull_o = 1'b1;
      w(4);
      scl_o = 1'b0;
   endtask

   // stop: data rises while clock high, bus left idle
   task automatic stop_c();
      w(1);
      sda_pull_o = 1'b1;
      w(2);
      scl_o = 1'b1;
      w(4);
      sda_pull_o = 1'b0;
      w(4);
   endtask

   // one bit of 400 ns: six cycles low with data set, two high
   task automatic bit_c(input logic b, output logic r);
      if (scl_o)
         scl_o = 1'b0;
      w(1);
      sda_pull_o = ~b;
      w(5);
      scl_o = 1'b1;
      w(2);
      r = sda_i;
      scl_o = 1'b0;
   endtask

   // byte out, msb first, then the acknowledge slot
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_c(d[i], r);
      bit_c(1'b1, r);
      ack = ~r;
   endtask

   // byte in; ack_m low leaves data high as a not-acknowledge
   task automatic recv(input logic ack_m, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_c(1'b1, d[i]);
      bit_c(~ack_m, r);
   endtask

   // recovery: start, nine ones, second start, stop
   task automatic recover();
      logic r;
      start_c();
      repeat (9) bit_c(1'b1, r);
      start_c();
      stop_c();
   endtask
endmodule

/* verif/i2c_slave_bus_recovery_tb_top.sv */
// self-checking bench for the recovering wiper slave
module i2c_slave_bus_recovery_tb_top;
   import i2c_recov_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk;
   logic rst;
   logic scl;
   logic pull;
   logic sda_oe;
   logic sda_out;
   logic nv_write;
   logic [WIPER_W-1:0] wiper;
   logic [WIPER_W-1:0] nv_data;
   wire sda = ~(sda_oe | pull); // open-drain wire with pull-up
   int error_cnt = 0;
   int compares = 0;
   int nv_cnt = 0; // stored-write pulses seen
   int oe_cnt = 0; // cycles the slave held data low
   logic ack;
   logic [7:0] rd;

   // 20 MHz system clock
   initial
      clk = 1'b0;
   always #25 clk = ~clk;

   wiper_slave dut_u (.clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_out), .sda_oe_o(sda_oe), .wiper_o(wiper),
      .nv_write_o(nv_write), .nv_data_o(nv_data));
   i2c_master_model mst_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));

   // counts write pulses and data drive cycles
   always @(posedge clk)
   begin
      if (nv_write === 1'b1)
         nv_cnt++;
      if (sda_oe === 1'b1)
         oe_cnt++;
   end

   // value comparison
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // start, address, command and optional data, each acknowledged
   task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
      input logic has_d);
      mst_u.start_c();
      mst_u.send({a, 1'b0}, ack);
      chk(9'(ack), 9'h001);
      mst_u.send(c, ack);
      chk(9'(ack), 9'h001);
      if (has_d)
      begin
         mst_u.send(d, ack);
         chk(9'(ack), 9'h001);
      end
      mst_u.w(6);
   endtask

   // outputs after reset
   task automatic t_reset();
      chk(wiper, WIPER_RST);
      chk(nv_data, WIPER_RST);
      chk(9'(sda_oe), 9'h000);
      chk(9'(sda_out), 9'h000);
      $display("test reset done");
   endtask

   // broadcast write, increment, decrement with saturation
   task automatic t_bcast();
      logic [7:0] c [6] = '{8'h01, 8'h04, 8'h08, 8'h00, 8'h08, 8'h04};
      logic [8:0] e [6] = '{9'h100, 9'h100, 9'h0FF, 9'h000, 9'h000, 9'h001};
      for (int i = 0; i < 6; i++)
      begin
         xfer(GC_ADDR, c[i], 8'h00, c[i][3:2] == OP_WRITE);
         chk(wiper, e[i]);
      end
      mst_u.stop_c();
      $display("test broadcast done");
   endtask

   // start in mid data byte drops the partial write
   task automatic t_restart();
      logic r;
      mst_u.start_c();
      mst_u.send({DEV_ADDR, 1'b0}, ack);
      mst_u.send(8'h00, ack);
      repeat (4) mst_u.bit_c(1'b1, r);
      xfer(DEV_ADDR, 8'h04, 8'h00, 1'b0);
      chk(wiper, 9'h002);
      mst_u.stop_c();
      $display("test restart done");
   endtask

   // slave stuck driving a zero read bit is freed by the sequence
   task automatic t_stuck();
      logic r;
      xfer(DEV_ADDR, 8'h00, 8'h00, 1'b1);
      mst_u.start_c();
      mst_u.send({DEV_ADDR, 1'b1}, ack);
      mst_u.bit_c(1'b1, r);
      mst_u.bit_c(1'b1, r);
      chk(9'(sda_oe), 9'h001);
      nv_cnt = 0;
      mst_u.recover();
      mst_u.w(4);
      chk(9'(sda_oe), 9'h000);
      chk(wiper, 9'h000);
      chk(9'(nv_cnt), 9'h000);
      xfer(DEV_ADDR, 8'h04, 8'h00, 1'b0);
      chk(wiper, 9'h001);
      mst_u.stop_c();
      $display("test stuck done");
   endtask

   // foreign address, nack after read, traffic without start
   task automatic t_idle();
      mst_u.start_c();
      mst_u.send({7'h11, 1'b0}, ack);
      chk(9'(ack), 9'h000);
      mst_u.start_c();
      mst_u.send({DEV_ADDR, 1'b1}, ack);
      mst_u.recv(1'b0, rd);
      chk(9'(rd), 9'h001);
      oe_cnt = 0;
      mst_u.send({DEV_ADDR, 1'b0}, ack);
      chk(9'(ack), 9'h000);
      mst_u.stop_c();
      mst_u.send({DEV_ADDR, 1'b0}, ack);
      chk(9'(oe_cnt), 9'h000);
      $display("test idle done");
   endtask

   // stored write only on stop; second start cancels it
   task automatic t_nv();
      nv_cnt = 0;
      xfer(DEV_ADDR, 8'h20, 8'h5A, 1'b1);
      chk(9'(nv_cnt), 9'h000);
      chk(nv_data, WIPER_RST);
      mst_u.stop_c();
      mst_u.w(6);
      chk(9'(nv_cnt), 9'h001);
      chk(nv_data, 9'h05A);
      nv_cnt = 0;
      xfer(DEV_ADDR, 8'h20, 8'hA5, 1'b1);
      mst_u.recover();
      mst_u.w(6);
      chk(9'(nv_cnt), 9'h000);
      chk(nv_data, 9'h05A);
      chk(wiper, 9'h001);
      $display("test stored write done");
   endtask

   // verdict and end of run
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog well past the expected run length
   initial
   begin
      #2000000;
      error_cnt++;
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_bcast();
      t_restart();
      t_stuck();
      t_idle();
      t_nv();
      tally_and_finish();
   end
endmodule
